// *** sdh_map.svh ***
// Register offsets, field positions, reset values and timing counts of the card host adapter.
// Included by the package, the top module and the bench; definitions only.
`ifndef SDH_MAP_SVH
`define SDH_MAP_SVH

// Register byte offsets on the APB side
`define SDH_OFS_POWER 12'h000
`define SDH_OFS_CLKCR 12'h004
`define SDH_OFS_ARG 12'h008
`define SDH_OFS_CMD 12'h00c
`define SDH_OFS_RIDX 12'h010
`define SDH_OFS_RARG 12'h014
`define SDH_OFS_DTMR 12'h018
`define SDH_OFS_DLEN 12'h01c
`define SDH_OFS_DCTRL 12'h020
`define SDH_OFS_STA 12'h024
`define SDH_OFS_ICR 12'h028
`define SDH_OFS_MSK 12'h02c
`define SDH_OFS_FIFO 12'h080

// Clock control fields
`define SDH_CLK_EN_BIT 8
`define SDH_CLK_WID_LSB 9
`define SDH_CLK_OD_BIT 11
`define SDH_CLK_MMC42_BIT 12
`define SDH_DIV_RESET 8'h3f

// Command fields
`define SDH_CMD_RSP_BIT 6
`define SDH_CMD_WDE_BIT 7
`define SDH_CMD_EN_BIT 8

// Data control fields
`define SDH_DC_EN_BIT 0
`define SDH_DC_DIR_BIT 1
`define SDH_DC_STRM_BIT 2

// Status flag positions
`define SDH_F_SENT 0
`define SDH_F_RESP 1
`define SDH_F_CTMO 2
`define SDH_F_CCRC 3
`define SDH_F_DEND 4
`define SDH_F_DTMO 5
`define SDH_NFLAG 6

// Timing counts in card clock cycles and buffer depth
`define SDH_CMD_BITS 6'd48
`define SDH_CMD_TMO_CYC 6'd63
`define SDH_FIFO_DEPTH 6'd32
`define SDH_DTMR_RESET 16'hffff

`endif

// *** sdh_pkg.sv ***
// Types shared by the card host adapter modules.
// Expects sdh_map.svh on the include path.
`include "sdh_map.svh"
package sdh_pkg;

  typedef enum logic [2:0] {
    CS_IDLE = 3'b000, CS_PEND = 3'b001, CS_SEND = 3'b010, CS_WAIT = 3'b011, CS_RECV = 3'b100
  } sdh_cmd_state_t;

  typedef enum logic [2:0] {
    DS_IDLE = 3'b000, DS_SSTART = 3'b001, DS_SEND = 3'b010, DS_SEND_END = 3'b011,
    DS_WAITR = 3'b100, DS_RECV = 3'b101, DS_RECV_END = 3'b110
  } sdh_dat_state_t;

  typedef struct packed {
    logic pwr; logic clken; logic [7:0] div; logic [1:0] wid; logic od; logic mmc42;
    logic [31:0] arg; logic [5:0] idx; logic rsp; logic wde; logic cen;
    logic [5:0] ridx; logic [31:0] rarg;
    logic den; logic ddir; logic strm; logic [15:0] dlen; logic [15:0] dtmr;
    logic [5:0] flg; logic [5:0] msk; logic inited;
    logic [7:0] dcnt; logic cclk;
    sdh_cmd_state_t cst; logic [47:0] csh; logic [5:0] cbit; logic cdrv; logic cout;
    logic cpo; logic cpe;
    sdh_dat_state_t dst; logic [31:0] dsh; logic [5:0] dbit; logic [15:0] wrem; logic [15:0] dto;
    logic [7:0] dout; logic ddrv; logic [7:0] dpe;
    logic [4:0] wp; logic [4:0] rp; logic [5:0] cnt; logic pushq; logic rdw; logic [31:0] prdata;
  } sdh_state_t;

  typedef struct packed {
    logic [31:0][31:0] mem; logic [31:0] rdata;
  } sdh_mem_state_t;

endpackage

// *** sdh_sync.sv ***
// Three-stage input synchroniser for pins from the card side.
// Assumes the input is asynchronous to clk; output moves only when stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module sdh_sync #(parameter int W = 1) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1; logic [W-1:0] s2; logic [W-1:0] s3; logic [W-1:0] q;
  } sync_st_t;
  sync_st_t s_q, s_d;

  // Filter per bit; the first stage feeds only the second
  always_comb begin
    s_d = s_q;
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < W; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) s_d.q[i] = s_q.s2[i];
    end
  end

  // Idle lines are pulled high on the card bus
  always_ff @(posedge clk) begin
    if (!rstn) s_q <= '1;
    else s_q <= s_d;
  end

  assign q = s_q.q;
endmodule
`default_nettype wire

// *** sdh_mem.sv ***
// Data buffer of 32 words by 32 bits with one write port and a registered read port.
// Read data show the word at raddr one clock after raddr is presented.
`timescale 1ns/10ps
`default_nettype none
module sdh_mem
  import sdh_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [4:0] raddr,
  output logic [31:0] rdata
);
  sdh_mem_state_t m_q, m_d;

  // Write and read in one pass; a same-cycle write is not bypassed
  always_comb begin
    m_d = m_q;
    if (we) m_d.mem[waddr] = wdata;
    m_d.rdata = m_q.mem[raddr];
  end

  always_ff @(posedge clk) begin
    if (!rstn) m_q <= '0;
    else m_q <= m_d;
  end

  assign rdata = m_q.rdata;
endmodule
`default_nettype wire

// *** sdh_top.sv ***
// Card host adapter: APB registers, card clock control, command path and data path.
// Assumes a 10 MHz CLK, external drivers on the card lines, and pull-ups on CMD and DAT.
// Behaviour
// - Data transfers are refused until one command has completed after power-up.
// - Each operation starts with a command; a response is awaited when requested.
// - Command tokens are shifted out serially on the command line.
// - Data moves either way over 1, 4 or 8 lines from line 0.
// - Block transfers with start and end bits, or streams without framing.
// - One bit per line per card clock cycle.
// - Card clock is programmable by divider and stays within card limits.
// - Eight-bit mode runs at the programmed card clock rate.
// - Command line open-drain when selected, push-pull otherwise.
// - Data lines push-pull; only line 0 after reset.
// - Four lines always allowed; eight only for the newer card type.
// - One card at a time for newer cards; several older ones by address.
// - Separate output enables for command and data lines.
// - APB register access, buffer traffic, interrupt and DMA requests.
// - Power control and card clock generation and gating.
// - A pending state holds a command until the data transfer ends.
// - No response start bit within 64 card cycles gives timeout and idle.
// - Buffer of 32 words of 32 bits, used for transmit or receive.
`timescale 1ns/10ps
`default_nettype none
`include "sdh_map.svh"
module sdh_top
  import sdh_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  output logic DMA_REQ,
  output logic CARD_CLOCK_PIN,
  input wire logic CMD_I,
  output logic CMD_O,
  output logic CMD_OE,
  input wire logic [7:0] DAT_I,
  output logic [7:0] DAT_O,
  output logic [7:0] DAT_OE
);
  sdh_state_t s, n;
  logic cmd_in;
  logic [7:0] dat_in;
  logic [31:0] mem_rdata;
  logic push, pop, avail, stall, rise, fall, tick, acc, wr, rd_go;
  logic apb_push, apb_pop, dp_push, dp_pop, bad, tx_act, rx_act;
  logic [31:0] push_data, rdv, word;
  logic [5:0] w;
  logic [7:0] lane_mask, lanes;

  sdh_sync #(.W(1)) u_cmd_sync (.clk(CLK), .rstn(RSTN), .d(CMD_I), .q(cmd_in));
  sdh_sync #(.W(8)) u_dat_sync (.clk(CLK), .rstn(RSTN), .d(DAT_I), .q(dat_in));
  sdh_mem u_buf (.clk(CLK), .rstn(RSTN), .we(push), .waddr(s.wp), .wdata(push_data),
    .raddr(s.rp), .rdata(mem_rdata));

  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) c = c ^ 7'h09;
    end
    return c;
  endfunction

  // Top w bits of a word, right-aligned onto the lanes
  function automatic logic [7:0] topw(input logic [31:0] x, input logic [5:0] wd);
    case (wd)
      6'd8: topw = x[31:24];
      6'd4: topw = {4'h0, x[31:28]};
      default: topw = {7'h00, x[31]};
    endcase
  endfunction

  // Effective bus width; a request for eight lines falls back to four on older cards
  always_comb begin
    if (s.wid[1] && s.mmc42) begin
      w = 6'd8;
      lane_mask = 8'hff;
    end else if (s.wid != 2'b00) begin
      w = 6'd4;
      lane_mask = 8'h0f;
    end else begin
      w = 6'd1;
      lane_mask = 8'h01;
    end
  end

  // Buffer view: a word pushed last cycle is not yet on the registered read port
  assign avail = (s.cnt > 6'd1) || (s.cnt == 6'd1 && !s.pushq);
  assign tx_act = !s.ddir && s.dst != DS_IDLE;
  assign rx_act = s.ddir && s.dst != DS_IDLE;
  // The card clock stops rather than under- or overrun the buffer
  assign stall = (s.dst == DS_SEND && s.dbit == 6'd0 && s.wrem != 16'h0 && !avail) ||
    (s.dst == DS_RECV && s.cnt == `SDH_FIFO_DEPTH);
  assign tick = s.pwr && s.clken && !stall && s.dcnt == s.div;
  assign rise = tick && !s.cclk;
  assign fall = tick && s.cclk;

  // APB decode; reads take two access cycles so PRDATA comes from a flop
  assign acc = PSEL && PENABLE;
  assign wr = acc && PWRITE;
  assign rd_go = acc && !PWRITE && !s.rdw;
  assign apb_push = wr && PADDR == `SDH_OFS_FIFO && s.cnt != `SDH_FIFO_DEPTH && !rx_act;
  assign apb_pop = rd_go && PADDR == `SDH_OFS_FIFO && avail && !tx_act;
  assign dp_push = s.dst == DS_RECV && rise && s.dbit + w == 6'd32;
  assign dp_pop = s.dst == DS_SEND && fall && s.dbit == 6'd0 && s.wrem != 16'h0;
  assign push = apb_push || dp_push;
  assign pop = apb_pop || dp_pop;
  assign word = (s.dsh << w) | {24'h0, dat_in & lane_mask};
  assign push_data = apb_push ? PWDATA : word;
  assign lanes = dat_in & lane_mask;

  always_comb begin
    bad = 1'b0;
    rdv = 32'h0;
    case (PADDR)
      `SDH_OFS_POWER: rdv = {31'h0, s.pwr};
      `SDH_OFS_CLKCR: rdv = {19'h0, s.mmc42, s.od, s.wid, s.clken, s.div};
      `SDH_OFS_ARG: rdv = s.arg;
      `SDH_OFS_CMD: rdv = {23'h0, s.cen, s.wde, s.rsp, s.idx};
      `SDH_OFS_RIDX: rdv = {26'h0, s.ridx};
      `SDH_OFS_RARG: rdv = s.rarg;
      `SDH_OFS_DTMR: rdv = {16'h0, s.dtmr};
      `SDH_OFS_DLEN: rdv = {16'h0, s.dlen};
      `SDH_OFS_DCTRL: rdv = {29'h0, s.strm, s.ddir, s.den};
      `SDH_OFS_STA: rdv = {10'h0, s.cnt, 1'b0, s.dst, 1'b0, s.cst, 2'b00, s.flg};
      `SDH_OFS_ICR: rdv = 32'h0;
      `SDH_OFS_MSK: rdv = {26'h0, s.msk};
      `SDH_OFS_FIFO: begin
        rdv = mem_rdata;
        bad = PWRITE ? (s.cnt == `SDH_FIFO_DEPTH || rx_act) : (!avail || tx_act);
      end
      default: bad = 1'b1;
    endcase
  end

  always_comb begin
    n = s;
    n.pushq = push;
    // Register side
    n.rdw = rd_go;
    if (rd_go) n.prdata = bad ? 32'h0 : rdv;
    if (push) n.wp = s.wp + 5'd1;
    if (pop) n.rp = s.rp + 5'd1;
    n.cnt = s.cnt + {5'h0, push} - {5'h0, pop};
    if (wr) begin
      case (PADDR)
        `SDH_OFS_POWER: n.pwr = PWDATA[0];
        `SDH_OFS_CLKCR: begin
          n.div = PWDATA[7:0];
          n.clken = PWDATA[`SDH_CLK_EN_BIT];
          n.wid = PWDATA[`SDH_CLK_WID_LSB +: 2];
          n.od = PWDATA[`SDH_CLK_OD_BIT];
          n.mmc42 = PWDATA[`SDH_CLK_MMC42_BIT];
        end
        `SDH_OFS_ARG: n.arg = PWDATA;
        `SDH_OFS_CMD: begin
          n.idx = PWDATA[5:0];
          n.rsp = PWDATA[`SDH_CMD_RSP_BIT];
          n.wde = PWDATA[`SDH_CMD_WDE_BIT];
          n.cen = PWDATA[`SDH_CMD_EN_BIT];
        end
        `SDH_OFS_DTMR: n.dtmr = PWDATA[15:0];
        `SDH_OFS_DLEN: n.dlen = PWDATA[15:0];
        `SDH_OFS_DCTRL: begin
          n.den = PWDATA[`SDH_DC_EN_BIT];
          n.ddir = PWDATA[`SDH_DC_DIR_BIT];
          n.strm = PWDATA[`SDH_DC_STRM_BIT];
        end
        `SDH_OFS_ICR: n.flg = s.flg & ~PWDATA[5:0]; // Hardware sets below win
        `SDH_OFS_MSK: n.msk = PWDATA[5:0];
        default: ;
      endcase
    end

    // Card clock divider: half period is div+1 system clocks
    if (!s.pwr || !s.clken) begin
      n.dcnt = 8'h00;
      n.cclk = 1'b0;
    end else if (tick) begin
      n.dcnt = 8'h00;
      n.cclk = !s.cclk;
    end else if (!stall) begin
      n.dcnt = s.dcnt + 8'h01;
    end

    // Command path: drive on falling card edges, sample on rising
    case (s.cst)
      CS_IDLE: begin
        if (s.cen) begin
          n.csh = {2'b01, s.idx, s.arg, crc7({2'b01, s.idx, s.arg}), 1'b1};
          n.cbit = 6'd0;
          n.cst = s.wde ? CS_PEND : CS_SEND;
        end
      end
      CS_PEND: begin
        if (!s.cen) n.cst = CS_IDLE;
        else if (s.dst == DS_IDLE) n.cst = CS_SEND;
      end
      CS_SEND: begin
        if (!s.cen) begin
          n.cst = CS_IDLE;
          n.cdrv = 1'b0;
        end else if (fall) begin
          if (s.cbit == `SDH_CMD_BITS) begin
            n.cdrv = 1'b0;
            n.cbit = 6'd0;
            if (s.rsp) begin
              n.cst = CS_WAIT;
            end else begin
              n.cst = CS_IDLE;
              n.cen = 1'b0;
              n.inited = 1'b1;
              n.flg[`SDH_F_SENT] = 1'b1;
            end
          end else begin
            n.cout = s.csh[47];
            n.csh = {s.csh[46:0], 1'b1};
            n.cdrv = 1'b1;
            n.cbit = s.cbit + 6'd1;
          end
        end
      end
      CS_WAIT: begin
        if (!s.cen) begin
          n.cst = CS_IDLE;
        end else if (rise) begin
          if (!cmd_in) begin
            n.csh = 48'h0;
            n.cbit = 6'd1;
            n.cst = CS_RECV;
          end else if (s.cbit == `SDH_CMD_TMO_CYC) begin
            n.cst = CS_IDLE;
            n.cen = 1'b0;
            n.flg[`SDH_F_CTMO] = 1'b1;
          end else begin
            n.cbit = s.cbit + 6'd1;
          end
        end
      end
      CS_RECV: begin
        if (!s.cen) begin
          n.cst = CS_IDLE;
        end else if (rise) begin
          n.csh = {s.csh[46:0], cmd_in};
          n.cbit = s.cbit + 6'd1;
          if (s.cbit == `SDH_CMD_BITS - 6'd1) begin
            n.cst = CS_IDLE;
            n.cen = 1'b0;
            n.ridx = n.csh[45:40];
            n.rarg = n.csh[39:8];
            n.inited = 1'b1;
            if (crc7(n.csh[47:8]) == n.csh[7:1]) n.flg[`SDH_F_RESP] = 1'b1;
            else n.flg[`SDH_F_CCRC] = 1'b1;
          end
        end
      end
      default: n.cst = CS_IDLE;
    endcase

    // Data path; finishing clears the enable so a transfer never repeats by itself
    case (s.dst)
      DS_IDLE: begin
        if (s.den && s.inited) begin
          n.wrem = s.dlen;
          n.dbit = 6'd0;
          n.dto = 16'h0;
          if (s.ddir) n.dst = s.strm ? DS_RECV : DS_WAITR;
          else n.dst = s.strm ? DS_SEND : DS_SSTART;
        end
      end
      DS_SSTART: begin
        if (fall) begin
          n.dout = 8'h00;
          n.ddrv = 1'b1;
          n.dst = DS_SEND;
        end
      end
      DS_SEND: begin
        if (fall) begin
          if (s.dbit == 6'd0 && s.wrem == 16'h0) begin
            n.dout = 8'hff;
            n.dst = s.strm ? DS_IDLE : DS_SEND_END;
            n.ddrv = !s.strm;
            n.den = !s.strm;
            if (s.strm) n.flg[`SDH_F_DEND] = 1'b1;
          end else begin
            n.ddrv = 1'b1;
            n.dout = topw(s.dbit == 6'd0 ? mem_rdata : s.dsh, w);
            n.dsh = (s.dbit == 6'd0 ? mem_rdata : s.dsh) << w;
            n.dbit = s.dbit + w;
            if (s.dbit + w == 6'd32) begin
              n.dbit = 6'd0;
              n.wrem = s.wrem - 16'h1;
            end
          end
        end
      end
      DS_SEND_END: begin
        if (fall) begin
          n.ddrv = 1'b0;
          n.den = 1'b0;
          n.dst = DS_IDLE;
          n.flg[`SDH_F_DEND] = 1'b1;
        end
      end
      DS_WAITR: begin
        if (rise) begin
          if (!lanes[0]) begin
            n.dst = DS_RECV;
          end else if (s.dto == s.dtmr) begin
            n.dst = DS_IDLE;
            n.den = 1'b0;
            n.flg[`SDH_F_DTMO] = 1'b1;
          end else begin
            n.dto = s.dto + 16'h1;
          end
        end
      end
      DS_RECV: begin
        if (s.wrem == 16'h0) begin
          n.dst = s.strm ? DS_IDLE : DS_RECV_END;
          n.den = !s.strm;
          if (s.strm) n.flg[`SDH_F_DEND] = 1'b1;
        end else if (rise) begin
          n.dsh = word;
          n.dbit = s.dbit + w;
          if (s.dbit + w == 6'd32) begin
            n.dbit = 6'd0;
            n.wrem = s.wrem - 16'h1;
          end
        end
      end
      DS_RECV_END: begin
        if (rise) begin
          n.dst = DS_IDLE;
          n.den = 1'b0;
          n.flg[`SDH_F_DEND] = 1'b1;
        end
      end
      default: n.dst = DS_IDLE;
    endcase

    // Software disable and power-off both abandon a transfer
    if ((!s.den && s.dst != DS_IDLE) || !s.pwr) begin
      n.dst = DS_IDLE;
      n.ddrv = 1'b0;
    end
    if (!s.pwr) begin
      n.cst = CS_IDLE;
      n.cdrv = 1'b0;
      n.inited = 1'b0;
    end

    // Pin stage: open-drain only ever pulls low
    n.cpo = n.od ? 1'b0 : n.cout;
    n.cpe = n.cdrv && (!n.od || !n.cout);
    n.dpe = n.ddrv ? lane_mask : 8'h00;
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      s <= '0;
      s.div <= `SDH_DIV_RESET;
      s.dtmr <= `SDH_DTMR_RESET;
      s.cout <= 1'b1;
      s.dout <= 8'hff;
    end else begin
      s <= n;
    end
  end

  assign PRDATA = s.prdata;
  assign PREADY = acc && (PWRITE || s.rdw);
  assign PSLVERR = PREADY && bad;
  assign IRQ = |(s.flg & s.msk);
  assign DMA_REQ = s.ddir ? rx_act && s.cnt != 6'd0 : tx_act && s.cnt != `SDH_FIFO_DEPTH;
  assign CARD_CLOCK_PIN = s.cclk;
  assign CMD_O = s.cpo;
  assign CMD_OE = s.cpe;
  assign DAT_O = s.dout;
  assign DAT_OE = s.dpe;
endmodule
`default_nettype wire

// *** sdh_props.sv ***
// Checker on the adapter ports: APB handshake and command line framing.
// Bound into sdh_top below; it sees the top module's ports only.
`timescale 1ns/10ps
`default_nettype none
module sdh_props (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ,
  input wire logic DMA_REQ,
  input wire logic CARD_CLOCK_PIN,
  input wire logic CMD_O,
  input wire logic CMD_OE,
  input wire logic [7:0] DAT_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic pin_q;
  logic [6:0] rise_q;
  // Card clock rises counted while the host drives the command line
  always_ff @(posedge CLK) begin
    pin_q <= CARD_CLOCK_PIN;
    if (!RSTN || !CMD_OE) begin
      rise_q <= 7'h00;
    end else if (CARD_CLOCK_PIN && !pin_q) begin
      rise_q <= rise_q + 7'h01;
    end
  end
  // Checked during reset too, not disabled by it
  property p_rst_quiet;
    disable iff (1'h0) !RSTN |=> !CMD_OE && DAT_OE == 8'h00 && !CARD_CLOCK_PIN && !IRQ && !DMA_REQ;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");
  property p_lanes; DAT_OE inside {8'h00, 8'h01, 8'h0f, 8'hff}; endproperty
  a_lanes: assert property (p_lanes) else $error("data enables not a lane group");
  property p_cmd_len; $fell(CMD_OE) |-> rise_q == 7'h30; endproperty
  a_cmd_len: assert property (p_cmd_len) else $error("command not 48 card clocks");
  property p_start; $rose(CMD_OE) |-> !CMD_O; endproperty
  a_start: assert property (p_start) else $error("command start bit not low");
  property p_end; $fell(CMD_OE) |-> $past(CMD_O); endproperty
  a_end: assert property (p_end) else $error("command end bit not high");
  // Except when clearing the command enable abandons a send, the enable moves only while the card clock is low, so the card never sees a half bit
  property p_oe_edge; $changed(CMD_OE) |-> !CARD_CLOCK_PIN; endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("command enable moved with clock high");
  property p_err; PSLVERR |-> PREADY; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rdy; PREADY |-> PSEL && PENABLE; endproperty
  a_rdy: assert property (p_rdy) else $error("ready outside access");
  property p_wr; PSEL && PENABLE && PWRITE |-> PREADY; endproperty
  a_wr: assert property (p_wr) else $error("write not ready at once");
  property p_rd; PSEL && PENABLE && !PWRITE && !$past(PENABLE) |-> !PREADY ##1 PREADY; endproperty
  a_rd: assert property (p_rd) else $error("read ready not in second access cycle");
  c_cmd: cover property ($fell(CMD_OE));
  c_err: cover property (PSLVERR);
  c_irq: cover property ($rose(IRQ));
endmodule
bind sdh_top sdh_props i_sdh_props (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .DMA_REQ(DMA_REQ), .CARD_CLOCK_PIN(CARD_CLOCK_PIN),
  .CMD_O(CMD_O), .CMD_OE(CMD_OE), .DAT_OE(DAT_OE));
`default_nettype wire

// *** sdh_card_model.sv ***
// Card model: takes commands, answers on request, sends one block on line 0.
// Assumes pull-ups on all card lines; it drives only after the card clock falls.
`timescale 1ns/10ps
`default_nettype none
module sdh_card_model (
  input wire logic ck,
  input wire logic cmd_o,
  input wire logic cmd_oe,
  input wire logic [7:0] dat_o,
  input wire logic [7:0] dat_oe,
  input wire logic resp_en,
  input wire logic dat_go,
  input wire logic [31:0] dat_word,
  output logic cmd_line,
  output logic [7:0] dat_line,
  output logic [47:0] got_cmd,
  output logic crc_ok,
  output logic [7:0] ncmd
);
  logic cdrv, cval;
  logic [7:0] ddrv, dval;
  logic [47:0] sh, rsp;
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      c = {c[5:0], 1'h0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    end
    return c;
  endfunction
  // Released lines float to the pull-up level, never to the last driven value
  assign cmd_line = cmd_oe ? cmd_o : (cdrv ? cval : 1'h1);
  assign dat_line = (dat_oe & dat_o) | (~dat_oe & (~ddrv | dval));
  initial begin
    cdrv = 1'h0;
    ddrv = 8'h00;
    dval = 8'hff;
    ncmd = 8'h00;
    crc_ok = 1'h0;
    got_cmd = 48'h0;
  end
  // Command intake one bit per rise, answer only when the bench asks for it
  always begin
    @(posedge ck iff (cmd_oe === 1'h1 && cmd_o === 1'h0));
    sh = 48'h0;
    for (int i = 0; i < 48; i++) begin
      if (i != 0) @(posedge ck);
      sh = {sh[46:0], cmd_o};
    end
    got_cmd = sh;
    crc_ok = (sh[7:1] == crc7(sh[47:8])) && sh[0];
    ncmd = ncmd + 8'h01;
    if (resp_en) begin
      rsp = {2'h0, sh[45:40], ~sh[39:8], 8'h01};
      rsp[7:1] = crc7(rsp[47:8]);
      repeat (3) @(negedge ck);
      for (int i = 47; i >= 0; i--) begin
        cdrv = 1'h1;
        cval = rsp[i];
        @(negedge ck);
      end
      cdrv = 1'h0;
    end
  end
  // One framed block on line 0: start bit, word MSB first, end bit
  always begin
    @(posedge dat_go);
    @(negedge ck);
    ddrv[0] = 1'h1;
    dval[0] = 1'h0;
    for (int i = 31; i >= 0; i--) begin
      @(negedge ck);
      dval[0] = dat_word[i];
    end
    @(negedge ck);
    dval[0] = 1'h1;
    @(negedge ck);
    ddrv[0] = 1'h0;
  end
endmodule
`default_nettype wire

// *** sdh_tb.sv ***
// Self-checking bench for the card host adapter: registers, commands, timeout, pending and receive.
// Assumes the card model on the card lines and the checker bound into the top module.
`timescale 1ns/10ps
`default_nettype none
`include "sdh_map.svh"
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module testbench
  import sdh_pkg::*;
;
  logic CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, DMA_REQ, CARD_CLOCK_PIN;
  logic CMD_I, CMD_O, CMD_OE, resp_en, dat_go, crc_ok, err, irq_s, oe_s;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd, dat_word;
  logic [7:0] DAT_I, DAT_O, DAT_OE, ncmd;
  logic [47:0] got_cmd;
  int bad_count, cmp_count;
  sdh_top i_sdh_top (.*);
  sdh_card_model i_sdh_card_model (.ck(CARD_CLOCK_PIN), .cmd_o(CMD_O), .cmd_oe(CMD_OE), .dat_o(DAT_O),
    .dat_oe(DAT_OE), .resp_en(resp_en), .dat_go(dat_go), .dat_word(dat_word), .cmd_line(CMD_I),
    .dat_line(DAT_I), .got_cmd(got_cmd), .crc_ok(crc_ok), .ncmd(ncmd));
  // 10 MHz system clock
  initial begin
    CLK = 1'h0;
    forever #50 CLK = ~CLK;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; the answer is taken at the edge that samples ready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1'h1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge CLK);
      if (PREADY === 1'h1) break;
    end
    rd = PRDATA;
    err = PSLVERR;
    irq_s = IRQ;
    oe_s = CMD_OE;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    if (n == 20) begin
      `CHK("apb ready", 1'h1, PREADY)
      end_sim();
    end
    @(posedge CLK);
  endtask
  // Poll the status word until one flag shows, with a bound
  task automatic wait_flag(input int b);
    int n;
    for (n = 0; n < 700; n++) begin
      apb(1'h0, `SDH_OFS_STA, 32'h0);
      if (rd[b] === 1'h1) break;
    end
    if (n == 700) begin
      `CHK("status flag", 1'h1, 1'h0)
      end_sim();
    end
  endtask
  task automatic t_reset();
    @(negedge CLK);
    `CHK("clock pin", 1'h0, CARD_CLOCK_PIN)
    `CHK("data enables", 8'h00, DAT_OE)
    `CHK("command enable", 1'h0, CMD_OE)
    @(posedge CLK);
    apb(1'h0, `SDH_OFS_CLKCR, 32'h0);
    `CHK("clock control reset", 32'h0000_003f, rd)
    apb(1'h0, `SDH_OFS_DTMR, 32'h0);
    `CHK("data timer reset", 32'h0000_ffff, rd)
    apb(1'h0, 12'h040, 32'h0);
    `CHK("unmapped error", 1'h1, err)
    `CHK("unmapped data", 32'h0, rd)
  endtask
  // Power up with divider 4: half period of five system cycles, and data refused before a command
  task automatic t_clock();
    int n, k;
    int t[2];
    logic last;
    apb(1'h1, `SDH_OFS_POWER, 32'h1);
    apb(1'h1, `SDH_OFS_CLKCR, 32'h0000_0104);
    k = 0;
    last = 1'h1;
    for (n = 0; n < 60 && k < 2; n++) begin
      @(negedge CLK);
      if (CARD_CLOCK_PIN === 1'h1 && last === 1'h0) begin
        t[k] = n;
        k++;
      end
      last = CARD_CLOCK_PIN;
    end
    `CHK("card clock period", 10, t[1] - t[0])
    @(posedge CLK);
    apb(1'h1, `SDH_OFS_DCTRL, 32'h3);
    apb(1'h0, `SDH_OFS_STA, 32'h0);
    `CHK("data refused", 3'h0, rd[14:12])
    apb(1'h1, `SDH_OFS_DCTRL, 32'h0);
  endtask
  // Send one command and judge its frame, the answer and the flag it raises
  task automatic t_cmd(input logic [5:0] idx, input logic [31:0] arg, input logic rsp, input logic ans,
    input int flag);
    logic [7:0] n0;
    n0 = ncmd;
    resp_en <= ans;
    apb(1'h1, `SDH_OFS_ARG, arg);
    apb(1'h1, `SDH_OFS_CMD, {23'h0, 1'h1, 1'h0, rsp, idx});
    wait_flag(flag);
    `CHK("command count", n0 + 8'h01, ncmd)
    `CHK("command frame", {2'h1, idx, arg}, got_cmd[47:8])
    `CHK("command check bits", 1'h1, crc_ok)
    `CHK("flag set", 32'h1 << flag, rd & 32'h3f)
    if (ans) begin
      apb(1'h0, `SDH_OFS_RIDX, 32'h0);
      `CHK("response index", {26'h0, idx}, rd)
      apb(1'h0, `SDH_OFS_RARG, 32'h0);
      `CHK("response argument", ~arg, rd)
    end
    apb(1'h1, `SDH_OFS_ICR, 32'h3f);
    apb(1'h0, `SDH_OFS_STA, 32'h0);
    `CHK("command path idle", 3'h0, rd[10:8])
  endtask
  // A command that waits for data end is held while a block comes in on line 0
  task automatic t_recv();
    apb(1'h1, `SDH_OFS_CMD, 32'h0000_0011);
    apb(1'h0, `SDH_OFS_STA, 32'h0);
    `CHK("disabled stays idle", 3'h0, rd[10:8])
    dat_word <= 32'hc3a5_0f96;
    apb(1'h1, `SDH_OFS_DLEN, 32'h1);
    apb(1'h1, `SDH_OFS_DCTRL, 32'h3);
    apb(1'h1, `SDH_OFS_CMD, 32'h0000_018c);
    apb(1'h0, `SDH_OFS_STA, 32'h0);
    `CHK("command pending", CS_PEND, rd[10:8])
    `CHK("command held back", 1'h0, oe_s)
    dat_go <= 1'h1;
    wait_flag(`SDH_F_DEND);
    dat_go <= 1'h0;
    wait_flag(`SDH_F_SENT);
    `CHK("held command sent", 6'h0c, got_cmd[45:40])
    apb(1'h1, `SDH_OFS_MSK, 32'h10);
    apb(1'h0, `SDH_OFS_STA, 32'h0);
    `CHK("data end request", 1'h1, irq_s)
    apb(1'h0, `SDH_OFS_FIFO, 32'h0);
    `CHK("received word", 32'hc3a5_0f96, rd)
    apb(1'h0, `SDH_OFS_FIFO, 32'h0);
    `CHK("empty buffer refused", 1'h1, err)
    apb(1'h1, `SDH_OFS_ICR, 32'h3f);
    apb(1'h0, `SDH_OFS_STA, 32'h0);
    `CHK("request cleared", 1'h0, irq_s)
  endtask
  // Main sequence after six cycles of reset
  initial begin
    RSTN = 1'h0;
    PSEL = 1'h0;
    PENABLE = 1'h0;
    PWRITE = 1'h0;
    PADDR = 12'h0;
    PWDATA = 32'h0;
    resp_en = 1'h0;
    dat_go = 1'h0;
    dat_word = 32'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge CLK);
    RSTN <= 1'h1;
    @(posedge CLK);
    t_reset();
    t_clock();
    t_cmd(6'h00, 32'h0, 1'h0, 1'h0, `SDH_F_SENT);
    t_cmd(6'h08, 32'h0000_01aa, 1'h1, 1'h1, `SDH_F_RESP);
    t_cmd(6'h37, 32'ha5a5_5a5a, 1'h1, 1'h0, `SDH_F_CTMO);
    t_recv();
    end_sim();
  end
endmodule
`default_nettype wire
